//--- verilog/ncl_device.sv
`timescale 1ns/1ps
module ncl_device
   import ncl_pkg::*;
#(
   parameter int WRITE_CYCLES = NCL_NVM_WRITE_CYCLES,
   parameter int DEPTH        = NCL_NVM_DEPTH
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   ncl_if.device     bus,
   input  wire logic chip_enable_in,
   input  wire logic power_on_request,
   input  wire logic program_supply,
   output logic      power_enable,
   output logic      fault_state,
   output logic      nvm_busy
);
   logic [1:0] scl_s;
   logic [1:0] sda_s;
   logic [1:0] ce_s;
   logic [1:0] pon_s;
   logic [1:0] sup_s;
   logic       scl_d;
   logic       sda_d;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_c;
   logic       stop_c;

   ncl_ph_e    ph_r;
   logic [3:0] cnt_r;
   logic [7:0] shift_r;
   logic [7:0] ptr_r;
   logic [7:0] tx_r;
   logic       sda_oe_r;
   logic [7:0] rd_byte;
   logic       wr_stb;

   logic [7:0] regs_r [DEPTH];
   logic [7:0] nvm_r [DEPTH];
   ncl_nvm_e   st_r;
   logic [7:0] nptr_r;
   logic [31:0] wcnt_r;
   logic       first_r;
   logic       busy;
   logic       cmd_prog_r;
   logic       cmd_recall_r;
   logic       nvf_r;
   logic       eev_r;
   logic       unv_r;
   logic       gate_active;
   logic       gate_fail;
   logic       fault_entry;
   logic       supply_bad;
   logic       clr_pair;

   // Pin synchronisers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         ce_s  <= 2'h0;
         pon_s <= 2'h0;
         sup_s <= 2'h0;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_s <= {scl_s[0], bus.scl};
         sda_s <= {sda_s[0], bus.sda};
         ce_s  <= {ce_s[0], chip_enable_in};
         pon_s <= {pon_s[0], power_on_request};
         sup_s <= {sup_s[0], program_supply};
         scl_d <= scl_s[1];
         sda_d <= sda_s[1];
      end
   end

   assign scl_rise = scl_s[1] & ~scl_d;
   assign scl_fall = ~scl_s[1] & scl_d;
   assign start_c  = scl_s[1] & scl_d & sda_d & ~sda_s[1];
   assign stop_c   = scl_s[1] & scl_d & ~sda_d & sda_s[1];
   assign busy     = (st_r != NV_IDLE) && (st_r != NV_FAULT);

   // Serial slave, bits sampled at SCL rise, driven after SCL fall
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ph_r     <= PH_IDLE;
         cnt_r    <= 4'h0;
         shift_r  <= 8'h00;
         ptr_r    <= 8'h00;
         tx_r     <= 8'h00;
         sda_oe_r <= 1'b0;
      end else if (start_c) begin
         ph_r     <= PH_DEV;
         // SCL fall after START is not a data bit
         cnt_r    <= 4'h8;
         sda_oe_r <= 1'b0;
      end else if (stop_c) begin
         ph_r     <= PH_IDLE;
         sda_oe_r <= 1'b0;
      end else if (ph_r != PH_IDLE && ph_r != PH_HOLD) begin
         if (scl_rise && cnt_r != 4'h8) begin
            shift_r <= {shift_r[6:0], sda_s[1]};
         end
         if (scl_rise && cnt_r == 4'h8 && ph_r == PH_RD && sda_s[1]) begin
            ph_r <= PH_HOLD;
         end
         if (scl_fall) begin
            if (cnt_r < 4'h7) begin
               cnt_r <= cnt_r + 4'h1;
               if (ph_r == PH_RD) begin
                  sda_oe_r <= ~tx_r[3'(4'h6 - cnt_r)];
               end
            end else if (cnt_r == 4'h7) begin
               cnt_r    <= 4'h8;
               sda_oe_r <= 1'b0;
               case (ph_r)
                  PH_DEV: begin
                     if (shift_r[7:1] == NCL_DEV_ADDR && !busy) begin
                        sda_oe_r <= 1'b1;
                        ph_r     <= shift_r[0] ? PH_RD : PH_REG;
                     end else begin
                        ph_r <= PH_HOLD;
                     end
                  end
                  PH_REG: begin
                     ptr_r    <= shift_r;
                     sda_oe_r <= 1'b1;
                     ph_r     <= PH_WR;
                  end
                  PH_WR: begin
                     sda_oe_r <= 1'b1;
                     ptr_r    <= ptr_r + 8'h01;
                  end
                  default: sda_oe_r <= 1'b0;
               endcase
            end else begin
               cnt_r <= 4'h0;
               if (ph_r == PH_RD) begin
                  tx_r     <= rd_byte;
                  sda_oe_r <= ~rd_byte[7];
                  ptr_r    <= ptr_r + 8'h01;
               end else begin
                  sda_oe_r <= 1'b0;
               end
            end
         end
      end
   end

   assign bus.dev_sda_oe = sda_oe_r;
   assign bus.dev_sda_o  = 1'b0;

   assign wr_stb = scl_fall && cnt_r == 4'h7 && ph_r == PH_WR && !start_c && !stop_c && !busy;

   always_comb begin
      if (ptr_r < 8'(DEPTH)) begin
         rd_byte = regs_r[ptr_r];
      end else if (ptr_r == NCL_STAT_ADDR) begin
         rd_byte = {5'h00, unv_r, eev_r, nvf_r};
      end else begin
         rd_byte = 8'h00;
      end
   end

   // Validity gate inputs
   always_comb begin
      gate_active = 1'b0;
      for (int i = int'(NCL_GATE_LO); i <= int'(NCL_GATE_HI); i++) begin
         gate_active = gate_active | (|regs_r[i]);
      end
   end
   assign gate_fail   = first_r && gate_active && regs_r[NCL_IDENT_A] == 8'h00
                        && regs_r[NCL_IDENT_B] == 8'h00;
   assign fault_entry = (st_r == NV_CHECK) && gate_fail;
   assign supply_bad  = (st_r == NV_LOAD || st_r == NV_PROG) && !sup_s[1];
   assign clr_pair    = wr_stb && ptr_r == NCL_STAT_ADDR && shift_r[NCL_STAT_NVF_BIT];

   // Volatile register space
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            regs_r[i] <= NCL_REG_RST;
         end
      end else if (st_r == NV_LOAD) begin
         regs_r[nptr_r] <= nvm_r[nptr_r];
      end else if (wr_stb && ptr_r < 8'(DEPTH)) begin
         regs_r[ptr_r] <= shift_r;
      end
   end

   // Nonvolatile array, written one byte per cycle in address order
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            nvm_r[i] <= NCL_REG_RST;
         end
      end else if (st_r == NV_PROG && sup_s[1]) begin
         nvm_r[nptr_r] <= regs_r[nptr_r];
      end
   end

   // Command bits wait for the STOP
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cmd_prog_r   <= 1'b0;
         cmd_recall_r <= 1'b0;
      end else if (wr_stb && ptr_r == NCL_CMD_ADDR) begin
         cmd_prog_r   <= shift_r[NCL_CMD_PROG_BIT];
         cmd_recall_r <= shift_r[NCL_CMD_RECALL_BIT];
      end else if (stop_c) begin
         cmd_prog_r   <= 1'b0;
         cmd_recall_r <= 1'b0;
      end
   end

   // Load and program sequencer
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_r    <= NV_OFF;
         nptr_r  <= 8'h00;
         wcnt_r  <= 32'h0;
         first_r <= 1'b0;
      end else if (!ce_s[1]) begin
         st_r <= NV_OFF;
      end else begin
         case (st_r)
            NV_OFF: begin
               st_r    <= NV_LOAD;
               nptr_r  <= 8'h00;
               first_r <= 1'b1;
            end
            NV_LOAD: begin
               nptr_r <= nptr_r + 8'h01;
               if (nptr_r == 8'(DEPTH - 1)) begin
                  st_r <= NV_CHECK;
               end
            end
            NV_CHECK: begin
               first_r <= 1'b0;
               st_r    <= (gate_fail || unv_r) ? NV_FAULT : NV_IDLE;
            end
            NV_FAULT, NV_IDLE: begin
               if (st_r == NV_FAULT && !unv_r) begin
                  st_r <= NV_IDLE;
               end
               if (stop_c && cmd_prog_r) begin
                  st_r   <= NV_PROG;
                  nptr_r <= 8'h00;
               end else if (stop_c && cmd_recall_r) begin
                  st_r   <= NV_LOAD;
                  nptr_r <= 8'h00;
               end
            end
            NV_PROG: begin
               nptr_r <= nptr_r + 8'h01;
               wcnt_r <= 32'h0;
               if (nptr_r == 8'(DEPTH - 1)) begin
                  st_r <= NV_WAIT;
               end
            end
            NV_WAIT: begin
               wcnt_r <= wcnt_r + 32'h1;
               if (wcnt_r == 32'(WRITE_CYCLES - 1)) begin
                  st_r   <= NV_LOAD;
                  nptr_r <= 8'h00;
               end
            end
            default: st_r <= NV_OFF;
         endcase
      end
   end

   // Fault latches, a set wins over a clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         nvf_r <= 1'b0;
         eev_r <= 1'b0;
         unv_r <= 1'b0;
      end else begin
         nvf_r <= fault_entry || supply_bad || (nvf_r && !clr_pair);
         unv_r <= fault_entry || (unv_r && !clr_pair);
         eev_r <= supply_bad || (eev_r && !(wr_stb && ptr_r == NCL_STAT_ADDR && shift_r[NCL_STAT_EEV_BIT]));
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         power_enable <= 1'b0;
         fault_state  <= 1'b0;
         nvm_busy     <= 1'b0;
      end else begin
         power_enable <= (st_r == NV_IDLE || st_r == NV_PROG || st_r == NV_WAIT) && pon_s[1];
         fault_state  <= st_r == NV_FAULT;
         nvm_busy     <= busy;
      end
   end
endmodule : ncl_device

//--- common/ncl_pkg.sv
// Functional notes
// - Unmapped address: ack writes, drop, read zero
// - Mapped address: ack, store, read back
// - Load state copies whole nonvolatile image
// - No reload until reset, enable toggle, recall, programming
// - Registers readable and writable at bus rate
// - Command bit 1 programs image at STOP
// - Programming: not acknowledge, keep other functions
// - After programming, reload image into registers
// - Eight banks, all rewritten each programming
// - Low supply sets both fault latches, no stall
// - Host prepares state, values, supply first
// - Host waits write time before further activity
// - Recall command reloads image into registers
// - Not acknowledge while image loads
// - First load unvalidated: halt, set two latches
// - Gate bypassed when 0xD9..0xDD all zero
// - Writing 1 clears latch pair, resumes power-up
// - Nonzero identifier marks data validated
// - Both identifiers zero: gate active again
// - Serial slave up to 400 kHz clock
// - Fault state ignores power-on request
package ncl_pkg;
   localparam logic [6:0] NCL_DEV_ADDR          = 7'h12;
   localparam logic [7:0] NCL_CMD_ADDR          = 8'hFF;
   localparam logic [7:0] NCL_STAT_ADDR         = 8'hFE;
   localparam int         NCL_CMD_RECALL_BIT    = 0;
   localparam int         NCL_CMD_PROG_BIT      = 1;
   localparam int         NCL_STAT_NVF_BIT      = 0;
   localparam int         NCL_STAT_EEV_BIT      = 1;
   localparam int         NCL_STAT_UNV_BIT      = 2;
   localparam logic [7:0] NCL_GATE_LO           = 8'hD9;
   localparam logic [7:0] NCL_GATE_HI           = 8'hDD;
   localparam logic [7:0] NCL_IDENT_A           = 8'hDE;
   localparam logic [7:0] NCL_IDENT_B           = 8'hDF;
   localparam int         NCL_NVM_DEPTH         = 224;
   localparam int         NCL_BANKS             = 8;
   localparam logic [7:0] NCL_REG_RST           = 8'h00;
   localparam int         NCL_CLK_MHZ           = 200;
   localparam int         NCL_NVM_WRITE_TIME_US = 10;
   localparam int         NCL_NVM_WRITE_CYCLES  = NCL_NVM_WRITE_TIME_US * NCL_CLK_MHZ;
   localparam int         NCL_SCL_KHZ           = 400;
   localparam int         NCL_QTR_CYCLES        = (NCL_CLK_MHZ * 1000) / (NCL_SCL_KHZ * 4);
   localparam logic [7:0] NCL_HOST_CMD_OFF      = 8'h00;
   localparam logic [7:0] NCL_HOST_STAT_OFF     = 8'h04;

   typedef enum logic [2:0] {NV_OFF, NV_LOAD, NV_CHECK, NV_FAULT, NV_IDLE, NV_PROG, NV_WAIT} ncl_nvm_e;
   typedef enum logic [2:0] {PH_IDLE, PH_DEV, PH_REG, PH_WR, PH_RD, PH_HOLD} ncl_ph_e;
   typedef enum logic [2:0] {HS_IDLE, HS_START, HS_BIT, HS_RSTART, HS_STOP} ncl_hst_e;
endpackage : ncl_pkg

//--- common/ncl_if.sv
`timescale 1ns/1ps
interface ncl_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic sda;

   // Open-drain wired AND of both drivers
   assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

   modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
endinterface : ncl_if

//--- verilog/ncl_host.sv
`timescale 1ns/1ps
module ncl_host
   import ncl_pkg::*;
#(
   parameter int QTR_CYCLES = NCL_QTR_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   ncl_if.host              bus
);
   logic        wr_pend_r;
   logic [7:0]  a_r;
   logic [16:0] cmd_r;
   logic        start_req;
   logic [15:0] qdiv_r;
   logic        tick;
   ncl_hst_e    hs_r;
   logic [1:0]  q_r;
   logic [3:0]  bit_r;
   logic [1:0]  byte_r;
   logic [7:0]  rx_r;
   logic [7:0]  rdata_r;
   logic        nack_r;
   logic        busy_r;
   logic        scl_r;
   logic        oe_r;
   logic [7:0]  tx_byte;
   logic        is_rx;
   logic        rd_cmd;
   logic [1:0]  sda_s;

   // SDA pin synchroniser
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sda_s <= 2'h3;
      end else begin
         sda_s <= {sda_s[0], bus.sda};
      end
   end

   assign rd_cmd    = cmd_r[16];
   assign start_req = wr_pend_r && a_r == NCL_HOST_CMD_OFF && !busy_r;

   // AHB-Lite slave, zero wait states
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wr_pend_r <= 1'b0;
         a_r       <= 8'h00;
         cmd_r     <= 17'h00000;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         wr_pend_r <= 1'b0;
         if (start_req) begin
            cmd_r <= hwdata[16:0];
         end
         if (hsel && htrans[1] && hready) begin
            wr_pend_r <= hwrite;
            a_r       <= haddr[7:0];
            if (!hwrite) begin
               case (haddr[7:0])
                  NCL_HOST_CMD_OFF:  hrdata <= {15'h0000, cmd_r};
                  NCL_HOST_STAT_OFF: hrdata <= {16'h0000, rdata_r, 6'h00, nack_r, busy_r};
                  default:           hrdata <= 32'h00000000;
               endcase
            end
         end
      end
   end

   always_comb begin
      case (byte_r)
         2'h0:    tx_byte = {NCL_DEV_ADDR, 1'b0};
         2'h1:    tx_byte = cmd_r[15:8];
         2'h2:    tx_byte = rd_cmd ? {NCL_DEV_ADDR, 1'b1} : cmd_r[7:0];
         default: tx_byte = 8'hFF;
      endcase
   end
   assign is_rx = byte_r == 2'h3;

   // Quarter bit period divider
   always_ff @(posedge mclk) begin
      if (!rst_n || start_req || qdiv_r == 16'(QTR_CYCLES - 1)) begin
         qdiv_r <= 16'h0000;
      end else begin
         qdiv_r <= qdiv_r + 16'h0001;
      end
   end
   assign tick = qdiv_r == 16'(QTR_CYCLES - 1);

   // Bus master sequencer
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hs_r    <= HS_IDLE;
         q_r     <= 2'h0;
         bit_r   <= 4'h0;
         byte_r  <= 2'h0;
         rx_r    <= 8'h00;
         rdata_r <= 8'h00;
         nack_r  <= 1'b0;
         busy_r  <= 1'b0;
         scl_r   <= 1'b1;
         oe_r    <= 1'b0;
      end else if (start_req) begin
         hs_r   <= HS_START;
         q_r    <= 2'h0;
         byte_r <= 2'h0;
         nack_r <= 1'b0;
         busy_r <= 1'b1;
      end else if (tick && hs_r != HS_IDLE) begin
         q_r <= q_r + 2'h1;
         case (hs_r)
            HS_START, HS_RSTART: begin
               case (q_r)
                  2'h0: begin
                     oe_r  <= 1'b0;
                     scl_r <= hs_r == HS_START;
                  end
                  2'h1: begin
                     if (hs_r == HS_START) oe_r <= 1'b1;
                     else scl_r <= 1'b1;
                  end
                  2'h2: begin
                     if (hs_r == HS_START) scl_r <= 1'b0;
                     else oe_r <= 1'b1;
                  end
                  default: begin
                     scl_r <= 1'b0;
                     bit_r <= 4'h0;
                     hs_r  <= HS_BIT;
                  end
               endcase
            end
            HS_BIT: begin
               case (q_r)
                  2'h0: oe_r <= (bit_r < 4'h8 && !is_rx) ? ~tx_byte[3'(4'h7 - bit_r)] : 1'b0;
                  2'h1: scl_r <= 1'b1;
                  2'h2: begin
                     if (bit_r < 4'h8 && is_rx) rx_r <= {rx_r[6:0], sda_s[1]};
                     if (bit_r == 4'h8 && !is_rx && sda_s[1]) nack_r <= 1'b1;
                  end
                  default: begin
                     scl_r <= 1'b0;
                     bit_r <= bit_r + 4'h1;
                     if (bit_r == 4'h8) begin
                        if (nack_r || is_rx || (byte_r == 2'h2 && !rd_cmd)) begin
                           hs_r <= HS_STOP;
                        end else if (byte_r == 2'h1 && rd_cmd) begin
                           hs_r   <= HS_RSTART;
                           byte_r <= 2'h2;
                        end else begin
                           bit_r  <= 4'h0;
                           byte_r <= byte_r + 2'h1;
                        end
                     end
                  end
               endcase
            end
            HS_STOP: begin
               case (q_r)
                  2'h0: begin
                     scl_r <= 1'b0;
                     oe_r  <= 1'b1;
                  end
                  2'h1: scl_r <= 1'b1;
                  2'h2: oe_r <= 1'b0;
                  default: begin
                     hs_r    <= HS_IDLE;
                     busy_r  <= 1'b0;
                     rdata_r <= rx_r;
                  end
               endcase
            end
            default: hs_r <= HS_IDLE;
         endcase
      end
   end

   assign bus.scl         = scl_r;
   assign bus.host_sda_oe = oe_r;
   assign bus.host_sda_o  = 1'b0;
endmodule : ncl_host

//--- verif/ncl_chk.sv
`timescale 1ns/1ps
module ncl_chk #(
   parameter int QTR_CYCLES = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic sda
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   logic [15:0] hold_r;

   // Length of the current device pull on SDA
   always_ff @(posedge mclk) begin
      if (!rst_n || !dev_sda_oe) begin
         hold_r <= 16'h0000;
      end else begin
         hold_r <= hold_r + 16'h0001;
      end
   end

   a_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o && !(host_sda_oe && scl))
      else $error("device drives SDA high");
   a_host_open_drain: assert property (host_sda_oe |-> !host_sda_o)
      else $error("host drives SDA high");
   a_sda_wired_and: assert property (sda == !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o)))
      else $error("SDA level does not match drivers");
   a_dev_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
      else $error("device moved SDA while SCL high");
   a_ack_through_high: assert property ($rose(scl) && dev_sda_oe |-> dev_sda_oe throughout scl [*3])
      else $error("device SDA level not held over SCL high");
   a_start_then_low: assert property (scl && $fell(sda) |-> ##[1:1000] !scl)
      else $error("SCL not driven low after START");
   a_stop_bus_free: assert property (scl && $rose(sda) |=> scl && sda)
      else $error("bus not free after STOP");
   a_scl_high_min: assert property ($rose(scl) |-> scl [*3])
      else $error("SCL high period too short");
   a_dev_hold_bound: assert property (hold_r <= 16'(40 * QTR_CYCLES))
      else $error("device holds SDA low too long");
endmodule : ncl_chk

//--- verif/nvm_config_load_program_tb.sv
`timescale 1ns/1ps
module nvm_config_load_program_tb
   import ncl_pkg::*;
;
   localparam int WR_CYC = 400;
   logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, r;
   integer      seed;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        chip_enable_in, power_on_request, program_supply;
   logic        power_enable, fault_state, nvm_busy, f, busy_q;
   logic [7:0]  regs [256];
   logic [7:0]  img [256];
   logic [15:0] gt [4] = '{16'h0000, 16'h3300, 16'h0044, 16'h0000};
   logic [7:0]  a;
   int          failures, cmp_count, rises, exp_rises;

   ncl_if lnk();
   ncl_host #(.QTR_CYCLES(8)) ncl_host_i (
      .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .bus(lnk.host)
   );
   ncl_device #(.WRITE_CYCLES(WR_CYC)) ncl_device_i (
      .mclk(mclk), .rst_n(rst_n), .bus(lnk.device), .chip_enable_in(chip_enable_in),
      .power_on_request(power_on_request), .program_supply(program_supply),
      .power_enable(power_enable), .fault_state(fault_state), .nvm_busy(nvm_busy)
   );
   ncl_chk #(.QTR_CYCLES(8)) ncl_chk_i (
      .mclk(mclk), .rst_n(rst_n), .scl(lnk.scl), .host_sda_o(lnk.host_sda_o),
      .host_sda_oe(lnk.host_sda_oe), .dev_sda_o(lnk.dev_sda_o), .dev_sda_oe(lnk.dev_sda_oe), .sda(lnk.sda)
   );

   always #2.5 mclk = ~mclk;

   // Busy rises, to spot loads nobody asked for
   always @(posedge mclk) begin
      if (rst_n === 1'b1 && nvm_busy === 1'b1 && busy_q !== 1'b1) rises++;
      busy_q = nvm_busy;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("Compared %0d, mismatched %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict

   task automatic ahb_xfer(input logic [31:0] ad, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      haddr <= ad;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb_xfer

   task automatic i2c_op(input logic rd, input logic [7:0] ra, input logic [7:0] wd,
                         output logic [7:0] q, output logic nk);
      logic [31:0] s;
      ahb_xfer(32'(NCL_HOST_CMD_OFF), 1'b1, {15'h0000, rd, ra, wd}, s);
      repeat (2) @(posedge mclk);
      s = 32'h00000001;
      while (s[0] !== 1'b0) ahb_xfer(32'(NCL_HOST_STAT_OFF), 1'b0, 32'h00000000, s);
      q = s[15:8];
      nk = s[1];
   endtask : i2c_op

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      logic [7:0] q;
      logic       nk;
      i2c_op(1'b0, ad, d, q, nk);
      if (ad < 8'hE0) regs[ad] = d;
   endtask : wr

   task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
      logic [7:0] q;
      logic       nk;
      i2c_op(1'b1, ad, 8'h00, q, nk);
      check({24'h000000, q}, {24'h000000, e});
      check(32'(hresp), 32'h0);
   endtask : rdc

   task automatic nvm_cmd(input logic [7:0] c);
      logic [7:0] q;
      logic       nk;
      logic       sup;
      sup = program_supply;
      wr(NCL_CMD_ADDR, c);
      exp_rises++;
      repeat (10) @(posedge mclk);
      check(32'(nvm_busy), 32'h1);
      if (c[1]) begin
         check(32'(power_enable), 32'(power_on_request));
         i2c_op(1'b0, 8'h10, 8'h99, q, nk);
         check(32'(nk), 32'h1);
         program_supply <= 1'b1;
      end
      while (nvm_busy !== 1'b0) @(posedge mclk);
      for (int i = 0; i < 224; i++) begin
         if (c[1] && sup) img[i] = regs[i];
         regs[i] = img[i];
      end
   endtask : nvm_cmd

   initial begin
      #480000;
      failures++;
      give_verdict();
   end

   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      hsel = 1'b1;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h00000000;
      chip_enable_in = 1'b0;
      power_on_request = 1'b1;
      program_supply = 1'b1;
      seed = 32'hA6C0;
      for (int i = 0; i < 256; i++) begin
         regs[i] = 8'h00;
         img[i] = 8'h00;
      end
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      chip_enable_in <= 1'b1;
      exp_rises = 1;
      repeat (10) @(posedge mclk);
      while (nvm_busy !== 1'b0) @(posedge mclk);
      check(32'(fault_state), 32'h0);
      check(32'(power_enable), 32'h1);
      power_on_request <= 1'b0;
      repeat (6) @(posedge mclk);
      check(32'(power_enable), 32'h0);
      power_on_request <= 1'b1;
      repeat (6) @(posedge mclk);
      for (int i = 0; i < 5; i++) begin
         r = $random(seed);
         a = r[7:0] % 8'hF0;
         wr(a, r[15:8]);
         rdc(a, a < 8'hE0 ? r[15:8] : 8'h00);
      end
      wr(8'hE7, 8'hA5);
      rdc(8'hE7, 8'h00);
      rdc(NCL_CMD_ADDR, 8'h00);
      r = $random(seed);
      wr(8'h05, r[7:0]);
      wr(8'hC8, r[15:8]);
      nvm_cmd(8'h02);
      rdc(8'h10, regs[16]);
      wr(8'h05, r[23:16]);
      wr(8'hC8, r[31:24]);
      nvm_cmd(8'h01);
      rdc(8'h05, r[7:0]);
      rdc(8'hC8, r[15:8]);
      program_supply <= 1'b0;
      wr(8'h05, 8'h77);
      nvm_cmd(8'h02);
      rdc(8'h05, r[7:0]);
      rdc(NCL_STAT_ADDR, 8'h03);
      check(32'(fault_state), 32'h0);
      wr(NCL_STAT_ADDR, 8'h03);
      rdc(NCL_STAT_ADDR, 8'h00);
      wr(NCL_GATE_LO, 8'h5A);
      for (int k = 0; k < 4; k++) begin
         f = (gt[k] == 16'h0000);
         wr(NCL_IDENT_A, gt[k][15:8]);
         wr(NCL_IDENT_B, gt[k][7:0]);
         nvm_cmd(8'h02);
         chip_enable_in <= 1'b0;
         repeat (8) @(posedge mclk);
         chip_enable_in <= 1'b1;
         exp_rises++;
         repeat (10) @(posedge mclk);
         while (nvm_busy !== 1'b0) @(posedge mclk);
         check(32'(fault_state), 32'(f));
         check(32'(power_enable), 32'(!f));
         rdc(NCL_STAT_ADDR, f ? 8'h05 : 8'h00);
         rdc(NCL_IDENT_A, gt[k][15:8]);
         if (f) begin
            wr(NCL_STAT_ADDR, 8'h01);
            repeat (10) @(posedge mclk);
            check(32'(fault_state), 32'h0);
            check(32'(power_enable), 32'h1);
         end
      end
      check(32'(rises), 32'(exp_rises));
      give_verdict();
   end
endmodule : nvm_config_load_program_tb
